// ===== src/cdpa_clock_ctrl.sv
// Clock divider, probe pin routing and idle clock gating with a Wishbone register slave
//
// Summary of operation
// - Memory clock field: stop, full or half
// - Peripheral clock is PLL clock over n+1
// - Peripheral divider ignored in bypass mode
// - Bus clock divides by one, two, four
// - Bus divider ignored in bypass mode
// - Probe A selects peripheral, RTC, oscillator
// - Probe A disabled passes general output
// - Probe B selects bus, peripheral, USB, oscillator, PLL
// - Probe B disabled turns the pin off
// - STOP halts peripheral clock, RTC keeps running
// - USB slave clock stops after 128 idle
// - RAM clock stops after 16 idle
// - ROM clock stops after 8 idle
// - Stopped block restarts with one extra cycle
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cdpa_defs.svh"
module cdpa_clock_ctrl
    import cdpa_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Mode and source clocks, sampled on clock
    input wire logic pll_run_mode,
    input wire logic stop_mode,
    input wire logic oscillator_enabled,
    input wire logic main_oscillator_clock,
    input wire logic rtc_clock,
    input wire logic usb_clock,
    input wire logic rtc_crystal_pll,
    input wire logic general_output_zero,
    // Divided clock strobes, one pulse per output clock period
    output logic bus_clock,
    output logic peripheral_bus_clock,
    output logic memory_data_clock,
    // Probe pins
    output logic probe_pin_a,
    output logic probe_pin_b,
    output logic probe_pin_b_oe,
    // Idle gating, index 2 USB slave, 1 internal_ram, 0 internal_rom
    input wire logic [2:0] block_access,
    output logic [2:0] block_clock_en,
    output logic [2:0] block_ready
);
    logic [31:0] div_reg;
    logic [31:0] next_div_reg;
    logic [31:0] test_reg;
    logic [31:0] next_test_reg;
    logic [31:0] auto_reg;
    logic [31:0] next_auto_reg;
    logic [31:0] next_dat_o;
    logic next_ack;
    logic [31:0] byte_mask;
    logic wb_req;

    ////////////////////////////////////////////////////////////////////////
    // Register slave: one wait cycle, unmapped reads give zero, writes dropped
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb begin
        next_div_reg = div_reg;
        next_test_reg = test_reg;
        next_auto_reg = auto_reg;
        next_ack = wb_req;
        next_dat_o = 32'h00000000;
        if (wb_req) begin
            case (wb_adr_i)
                `CDPA_ADR_DIV: begin
                    next_dat_o = div_reg & `CDPA_MASK_DIV;
                    if (wb_we_i) begin
                        next_div_reg = (div_reg & ~byte_mask) | (wb_dat_i & byte_mask & `CDPA_MASK_DIV);
                    end
                end
                `CDPA_ADR_TEST: begin
                    next_dat_o = test_reg & `CDPA_MASK_TEST;
                    if (wb_we_i) begin
                        next_test_reg = (test_reg & ~byte_mask) | (wb_dat_i & byte_mask & `CDPA_MASK_TEST);
                    end
                end
                `CDPA_ADR_AUTO: begin
                    // Reserved bits are not stored and read as zero
                    next_dat_o = auto_reg & `CDPA_MASK_AUTO;
                    if (wb_we_i) begin
                        next_auto_reg = (auto_reg & ~byte_mask) | (wb_dat_i & byte_mask & `CDPA_MASK_AUTO);
                    end
                end
                `CDPA_ADR_STAT: begin
                    next_dat_o = {26'h0000000, stop_mode, pll_run_mode, 1'b0, block_clock_en};
                end
                default: begin
                    next_dat_o = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_reg <= `CDPA_RST_DIV;
            test_reg <= `CDPA_RST_TEST;
            auto_reg <= `CDPA_RST_AUTO;
            wb_dat_o <= 32'h00000000;
            wb_ack_o <= 1'b0;
        end else begin
            div_reg <= next_div_reg;
            test_reg <= next_test_reg;
            auto_reg <= next_auto_reg;
            wb_dat_o <= next_dat_o;
            wb_ack_o <= next_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dividers: a new setting is loaded only when the count wraps
    logic [1:0] bus_cnt;
    logic [1:0] next_bus_cnt;
    logic [1:0] bus_limit;
    logic [4:0] per_cnt;
    logic [4:0] next_per_cnt;
    logic mem_phase;
    logic [1:0] mem_mode;
    logic [1:0] next_mem_mode;
    logic next_bus_clock;
    logic next_per_clock;
    logic next_mem_clock;

    always_comb begin
        case (div_reg[`CDPA_BUS_HI:`CDPA_BUS_LO])
            `CDPA_BUS_DIV1: bus_limit = `CDPA_BUS_LIM1;
            `CDPA_BUS_DIV2: bus_limit = `CDPA_BUS_LIM2;
            default: bus_limit = `CDPA_BUS_LIM4;
        endcase
        next_bus_cnt = (bus_cnt == 2'h0) ? bus_limit : bus_cnt - 2'h1;
        next_per_cnt = (per_cnt == 5'h00) ? div_reg[`CDPA_PER_HI:`CDPA_PER_LO] : per_cnt - 5'h01;
        next_bus_clock = (bus_cnt == 2'h0);
        next_per_clock = (per_cnt == 5'h00);
        if (!pll_run_mode) begin
            // Bypass: both clocks follow the undivided input
            next_bus_cnt = 2'h0;
            next_per_cnt = 5'h00;
            next_bus_clock = 1'b1;
            next_per_clock = 1'b1;
        end
        if (stop_mode) begin
            next_per_clock = 1'b0;
        end
        next_mem_mode = mem_phase ? mem_mode : div_reg[`CDPA_MEM_HI:`CDPA_MEM_LO];
        case (mem_mode)
            `CDPA_MEM_FULL: next_mem_clock = 1'b1;
            `CDPA_MEM_HALF: next_mem_clock = !mem_phase;
            default: next_mem_clock = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bus_cnt <= 2'h0;
            per_cnt <= 5'h00;
            mem_phase <= 1'b0;
            mem_mode <= `CDPA_MEM_STOP;
            bus_clock <= 1'b0;
            peripheral_bus_clock <= 1'b0;
            memory_data_clock <= 1'b0;
        end else begin
            bus_cnt <= next_bus_cnt;
            per_cnt <= next_per_cnt;
            mem_phase <= !mem_phase;
            mem_mode <= next_mem_mode;
            bus_clock <= next_bus_clock;
            peripheral_bus_clock <= next_per_clock;
            memory_data_clock <= next_mem_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Probe routing: source changes are taken only while the pin is low,
    // trading a short delay for no runt pulses on the pin
    logic [1:0] pa_sel;
    logic [1:0] next_pa_sel;
    logic [2:0] pb_sel;
    logic [2:0] next_pb_sel;
    logic osc_gated;
    logic next_probe_a;
    logic next_probe_b;
    logic pa_src;
    logic pb_src;

    assign osc_gated = main_oscillator_clock && oscillator_enabled;

    always_comb begin
        next_pa_sel = probe_pin_a ? pa_sel : test_reg[`CDPA_PA_SEL_HI:`CDPA_PA_SEL_LO];
        next_pb_sel = probe_pin_b ? pb_sel : test_reg[`CDPA_PB_SEL_HI:`CDPA_PB_SEL_LO];
        case (pa_sel)
            `CDPA_PA_PERIPH: pa_src = peripheral_bus_clock;
            `CDPA_PA_RTC: pa_src = rtc_clock;
            `CDPA_PA_OSC: pa_src = osc_gated;
            default: pa_src = 1'b0;
        endcase
        case (pb_sel)
            `CDPA_PB_BUS: pb_src = bus_clock;
            `CDPA_PB_PERIPH: pb_src = peripheral_bus_clock;
            `CDPA_PB_USB: pb_src = usb_clock;
            `CDPA_PB_OSC: pb_src = osc_gated;
            `CDPA_PB_RTCPLL: pb_src = rtc_crystal_pll;
            default: pb_src = 1'b0;
        endcase
        next_probe_a = test_reg[`CDPA_PA_EN] ? pa_src : general_output_zero;
        next_probe_b = test_reg[`CDPA_PB_EN] && pb_src;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pa_sel <= `CDPA_PA_PERIPH;
            pb_sel <= `CDPA_PB_BUS;
            probe_pin_a <= 1'b0;
            probe_pin_b <= 1'b0;
            probe_pin_b_oe <= 1'b0;
        end else begin
            pa_sel <= next_pa_sel;
            pb_sel <= next_pb_sel;
            probe_pin_a <= next_probe_a;
            probe_pin_b <= next_probe_b;
            probe_pin_b_oe <= test_reg[`CDPA_PB_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Idle gates, one per block
    localparam int IDLE_LIMITS [`CDPA_NGATE] = '{`CDPA_IDLE_USB, `CDPA_IDLE_RAM, `CDPA_IDLE_ROM};
    logic [2:0] force_on;

    assign force_on = {auto_reg[`CDPA_AG_USB], auto_reg[`CDPA_AG_RAM], auto_reg[`CDPA_AG_ROM]};

    genvar gi;
    generate
        for (gi = 0; gi < `CDPA_NGATE; gi++) begin : g_gate
            cdpa_gate_if gif ();
            assign gif.bus_tick = bus_clock;
            assign gif.always_on = force_on[gi];
            assign gif.access = block_access[gi];
            assign block_clock_en[gi] = gif.clk_en;
            assign block_ready[gi] = gif.ready;
            cdpa_idle_gate #(
                .IDLE_LIMIT(IDLE_LIMITS[`CDPA_NGATE - 1 - gi])
            ) u_gate (
                .clock(clock),
                .rstn(rstn),
                .g(gif.gate)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    sequence s_half_mem;
        (mem_mode == `CDPA_MEM_HALF) && (next_mem_mode == `CDPA_MEM_HALF);
    endsequence

    a_mem_stopped: assert property (@(posedge clock) disable iff (!rstn)
        (mem_mode == `CDPA_MEM_STOP) |=> !memory_data_clock)
        else $error("memory clock ran while stopped");

    a_mem_half_rate: assert property (@(posedge clock) disable iff (!rstn)
        s_half_mem ##1 s_half_mem |=> (memory_data_clock != $past(memory_data_clock)))
        else $error("half speed memory clock did not alternate");

    a_bus_bypass: assert property (@(posedge clock) disable iff (!rstn)
        (!pll_run_mode) |=> bus_clock)
        else $error("bus divider acted in bypass mode");

    a_bus_div_four: assert property (@(posedge clock) disable iff (!rstn)
        (pll_run_mode && bus_clock && bus_cnt == `CDPA_BUS_LIM4) ##1 pll_run_mode[*2] |-> !bus_clock[*2])
        else $error("bus clock divide by four pulsed early");

    a_periph_stop: assert property (@(posedge clock) disable iff (!rstn)
        stop_mode |=> !peripheral_bus_clock)
        else $error("peripheral clock ran in stop mode");

    a_probe_a_gpo: assert property (@(posedge clock) disable iff (!rstn)
        !test_reg[`CDPA_PA_EN] |=> (probe_pin_a == $past(general_output_zero)))
        else $error("probe A did not pass the general output");

    a_probe_b_off: assert property (@(posedge clock) disable iff (!rstn)
        !test_reg[`CDPA_PB_EN] |=> (!probe_pin_b && !probe_pin_b_oe))
        else $error("probe B driven while disabled");

    a_wb_ack_once: assert property (@(posedge clock) disable iff (!rstn)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("register access not answered in one cycle");
endmodule
`default_nettype wire

// ===== src/cdpa_defs.svh
// Register map, field positions, codes and counts for the clock divider, probe and autogate block
`ifndef CDPA_DEFS_SVH
`define CDPA_DEFS_SVH
`define CDPA_ADR_DIV 32'h40004040
`define CDPA_ADR_TEST 32'h400040a4
`define CDPA_ADR_AUTO 32'h400040ec
`define CDPA_ADR_STAT 32'h400040f0
`define CDPA_MASK_DIV 32'h000001ff
`define CDPA_MASK_TEST 32'h0000007f
`define CDPA_MASK_AUTO 32'h00000043
`define CDPA_RST_DIV 32'h00000000
`define CDPA_RST_TEST 32'h00000000
`define CDPA_RST_AUTO 32'h00000000
`define CDPA_MEM_HI 8
`define CDPA_MEM_LO 7
`define CDPA_PER_HI 6
`define CDPA_PER_LO 2
`define CDPA_BUS_HI 1
`define CDPA_BUS_LO 0
`define CDPA_PA_SEL_HI 6
`define CDPA_PA_SEL_LO 5
`define CDPA_PA_EN 4
`define CDPA_PB_SEL_HI 3
`define CDPA_PB_SEL_LO 1
`define CDPA_PB_EN 0
`define CDPA_AG_USB 6
`define CDPA_AG_RAM 1
`define CDPA_AG_ROM 0
`define CDPA_MEM_STOP 2'h0
`define CDPA_MEM_FULL 2'h1
`define CDPA_MEM_HALF 2'h2
`define CDPA_BUS_DIV1 2'h0
`define CDPA_BUS_DIV2 2'h1
`define CDPA_BUS_LIM1 2'h0
`define CDPA_BUS_LIM2 2'h1
`define CDPA_BUS_LIM4 2'h3
`define CDPA_PA_PERIPH 2'h0
`define CDPA_PA_RTC 2'h1
`define CDPA_PA_OSC 2'h2
`define CDPA_PB_BUS 3'h0
`define CDPA_PB_PERIPH 3'h1
`define CDPA_PB_USB 3'h2
`define CDPA_PB_OSC 3'h5
`define CDPA_PB_RTCPLL 3'h7
`define CDPA_IDLE_USB 128
`define CDPA_IDLE_RAM 16
`define CDPA_IDLE_ROM 8
`define CDPA_NGATE 3
`define CDPA_GATE_USB 2
`define CDPA_GATE_RAM 1
`define CDPA_GATE_ROM 0
`endif

// ===== src/cdpa_pkg.sv
// Types shared by the clock divider, probe and autogate block
package cdpa_pkg;
    typedef enum logic [0:0] {
        CDPA_GATE_STOP = 1'b0,
        CDPA_GATE_RUN = 1'b1
    } cdpa_gate_state_t;
endpackage

// ===== src/cdpa_gate_if.sv
// Signals between the clock controller and one idle clock gate
`timescale 1ns/1ps
`default_nettype none
interface cdpa_gate_if;
    logic bus_tick;
    logic always_on;
    logic access;
    logic clk_en;
    logic ready;
    modport ctrl (output bus_tick, output always_on, output access, input clk_en, input ready);
    modport gate (input bus_tick, input always_on, input access, output clk_en, output ready);
endinterface
`default_nettype wire

// ===== src/cdpa_idle_gate.sv
// Idle clock gate for one block: stops its clock after a run of idle bus ticks
`timescale 1ns/1ps
`default_nettype none
`include "cdpa_defs.svh"
module cdpa_idle_gate
    import cdpa_pkg::*;
#(
    parameter int IDLE_LIMIT = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Controller side
    cdpa_gate_if.gate g
);
    cdpa_gate_state_t state;
    cdpa_gate_state_t next_state;
    logic [7:0] idle_cnt;
    logic [7:0] next_idle_cnt;
    logic ready;
    logic next_ready;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_idle_cnt = idle_cnt;
        next_ready = ready;
        if (g.bus_tick) begin
            if (g.access) begin
                next_idle_cnt = 8'h00;
                case (state)
                    // Restart costs exactly one bus tick before the answer
                    CDPA_GATE_STOP: begin
                        next_state = CDPA_GATE_RUN;
                        next_ready = 1'b0;
                    end
                    CDPA_GATE_RUN: begin
                        next_ready = 1'b1;
                    end
                    default: begin
                        next_state = CDPA_GATE_RUN;
                    end
                endcase
            end else begin
                next_ready = 1'b0;
                if (state == CDPA_GATE_RUN) begin
                    if (idle_cnt == 8'(IDLE_LIMIT - 1)) begin
                        next_state = CDPA_GATE_STOP;
                        next_idle_cnt = 8'h00;
                    end else begin
                        next_idle_cnt = idle_cnt + 8'h01;
                    end
                end
            end
        end
        if (g.always_on) begin
            next_state = CDPA_GATE_RUN;
            next_idle_cnt = 8'h00;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= CDPA_GATE_RUN;
            idle_cnt <= 8'h00;
            ready <= 1'b0;
        end else begin
            state <= next_state;
            idle_cnt <= next_idle_cnt;
            ready <= next_ready;
        end
    end

    // Gate enable changes only on a controller edge, never mid-pulse
    assign g.clk_en = (state == CDPA_GATE_RUN);
    assign g.ready = ready;

    ////////////////////////////////////////////////////////////////////////
    sequence s_cold_access;
        g.bus_tick && g.access && !g.always_on && (state == CDPA_GATE_STOP);
    endsequence

    sequence s_restart;
        (state == CDPA_GATE_RUN) && !ready;
    endsequence

    a_restart_one_cycle: assert property (@(posedge clock) disable iff (!rstn)
        s_cold_access |=> s_restart)
        else $error("stopped gate did not restart with one cycle of latency");

    a_warm_access_ready: assert property (@(posedge clock) disable iff (!rstn)
        (g.bus_tick && g.access && state == CDPA_GATE_RUN) |=> ready)
        else $error("running gate did not answer an access");

    a_stop_after_idle: assert property (@(posedge clock) disable iff (!rstn)
        $fell(state == CDPA_GATE_RUN) |-> ($past(idle_cnt) == 8'(IDLE_LIMIT - 1)) && !$past(g.access))
        else $error("gate stopped before the idle limit");

    a_always_clocked: assert property (@(posedge clock) disable iff (!rstn)
        g.always_on |=> (state == CDPA_GATE_RUN))
        else $error("gate stopped while forced on");
endmodule
`default_nettype wire

// ===== sim/tb_cdpa_clock_ctrl.sv
// Self-checking testbench for the clock divider, probe and autogate block
`timescale 1ns/1ps
`default_nettype none
`include "cdpa_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_cdpa_clock_ctrl;
    typedef struct {logic [31:0] adr; logic [31:0] wd; logic [31:0] rd; int nb; int np; int nm;} cdpa_tb_row_t;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat;
    logic ack;
    logic pll = 1'b1;
    logic stp = 1'b0;
    logic osc_en = 1'b1;
    logic osc = 1'b0;
    logic rtc = 1'b1;
    logic usb = 1'b1;
    logic rpll = 1'b1;
    logic gpo = 1'b0;
    logic bclk, pclk, mclk, pa, pb, pb_oe;
    logic [2:0] acc = 3'h0;
    logic [2:0] cen, rdy;
    logic [31:0] r;
    int n_fail = 0;
    int compares = 0;
    int cb, cp, cm, k1, k2, k3, k4;
    int lims [3] = '{`CDPA_IDLE_ROM, `CDPA_IDLE_RAM, `CDPA_IDLE_USB};
    // Divider rows first, then plain register rows (negative counts skip the strobe check)
    // Each divider row starts from reset, since software sets the divider only once
    cdpa_tb_row_t rows [9] = '{
        '{`CDPA_ADR_DIV, 32'h00000081, 32'h00000081, 48, 96, 96},
        '{`CDPA_ADR_DIV, 32'h0000010a, 32'h0000010a, 24, 32, 48},
        '{`CDPA_ADR_DIV, 32'h0000007c, 32'h0000007c, 96, 3, 0},
        '{`CDPA_ADR_DIV, 32'hffffffff, 32'h000001ff, 24, 3, 0},
        '{`CDPA_ADR_DIV, 32'h00000000, 32'h00000000, 96, 96, 0},
        '{`CDPA_ADR_TEST, 32'hffffffff, 32'h0000007f, -1, -1, -1},
        '{`CDPA_ADR_AUTO, 32'h00000043, 32'h00000043, -1, -1, -1},
        '{32'h40004044, 32'hffffffff, 32'h00000000, -1, -1, -1},
        '{`CDPA_ADR_AUTO, 32'h00000000, 32'h00000000, -1, -1, -1}};
    logic [6:0] pv [9] = '{7'h00, 7'h31, 7'h5b, 7'h13, 7'h05, 7'h0f, 7'h07, 7'h09, 7'h0d};
    logic [2:0] pe [9] = '{3'b000, 3'b111, 3'b001, 3'b111, 3'b011, 3'b011, 3'b001, 3'b001, 3'b001};

    cdpa_clock_ctrl i_dut (
        .clock(clock), .rstn(rstn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack),
        .pll_run_mode(pll), .stop_mode(stp), .oscillator_enabled(osc_en), .main_oscillator_clock(osc),
        .rtc_clock(rtc), .usb_clock(usb), .rtc_crystal_pll(rpll), .general_output_zero(gpo),
        .bus_clock(bclk), .peripheral_bus_clock(pclk), .memory_data_clock(mclk),
        .probe_pin_a(pa), .probe_pin_b(pb), .probe_pin_b_oe(pb_oe),
        .block_access(acc), .block_clock_en(cen), .block_ready(rdy)
    );

    initial begin
        forever #5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("fails=%0d compares=%0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Outputs are read in the edge's own time step, before its updates land
    // Waits for the answer however long it takes; only the watchdog ends a hang
    task wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rv);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        rv = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        wb(1'b1, a, d, r);
    endtask

    task rchk(input logic [31:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, r);
        `CHK(r, e)
    endtask

    // Settle long enough for the slowest divider period to roll over
    task cnt;
        cb = 0;
        cp = 0;
        cm = 0;
        repeat (40) @(posedge clock);
        repeat (96) begin
            @(posedge clock);
            cb += bclk;
            cp += pclk;
            cm += mclk;
        end
    endtask

    task lat(input int g, output int k);
        @(posedge clock);
        acc[g] <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (rdy[g] !== 1'b1 && k < 20);
        acc[g] <= 1'b0;
    endtask

    task idle(input int g, output int k);
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (cen[g] !== 1'b0 && k < 300);
    endtask

    task do_reset;
        rstn <= 1'b0;
        repeat (6) @(posedge clock);
        `CHK({ack, rdat, bclk, pclk, mclk, pa, pb, pb_oe, cen, rdy}, 45'h38)
        rstn <= 1'b1;
        rchk(`CDPA_ADR_DIV, `CDPA_RST_DIV);
        rchk(`CDPA_ADR_TEST, `CDPA_RST_TEST);
        rchk(`CDPA_ADR_AUTO, `CDPA_RST_AUTO);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        test_done;
    end

    initial begin
        do_reset;
        foreach (rows[i]) begin
            if (rows[i].nb >= 0) begin
                do_reset;
            end
            wr(rows[i].adr, rows[i].wd);
            rchk(rows[i].adr, rows[i].rd);
            if (rows[i].nb >= 0) begin
                cnt;
                `CHK(cb, rows[i].nb)
                `CHK(cp, rows[i].np)
                `CHK(cm, rows[i].nm)
            end
        end
        // Bypass must ignore both dividers; no memory traffic is issued while bypassed
        do_reset;
        wr(`CDPA_ADR_DIV, 32'h0000010a);
        pll <= 1'b0;
        cnt;
        `CHK({cb, cp}, {32'd96, 32'd96})
        pll <= 1'b1;
        stp <= 1'b1;
        cnt;
        `CHK(cp, 0)
        stp <= 1'b0;
        do_reset;
        // Pins are parked at 0 between rows so a new select is always taken
        foreach (pv[i]) begin
            wr(`CDPA_ADR_TEST, 32'h0);
            wr(`CDPA_ADR_TEST, {25'h0, pv[i]});
            repeat (4) @(posedge clock);
            `CHK({pa, pb, pb_oe}, pe[i])
        end
        // Probe A disabled must follow the general output when it goes high
        gpo <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK({pa, pb, pb_oe}, 3'b101)
        gpo <= 1'b0;
        osc <= 1'b1;
        wr(`CDPA_ADR_TEST, 32'h0000005b);
        stp <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK({pa, pb, pb_oe}, 3'b111)
        osc_en <= 1'b0;
        repeat (4) @(posedge clock);
        `CHK({pa, pb, pb_oe}, 3'b001)
        wr(`CDPA_ADR_TEST, 32'h00000013);
        repeat (4) @(posedge clock);
        `CHK({pa, pb, pb_oe}, 3'b001)
        stp <= 1'b0;
        osc_en <= 1'b1;
        for (int g = 0; g < 3; g++) begin
            lat(g, k1);
            lat(g, k2);
            `CHK(k2, 2)
            idle(g, k3);
            `CHK((k3 >= lims[g] + 1 && k3 <= lims[g] + 2), 1'b1)
            lat(g, k4);
            `CHK(k4 - k2, 1)
        end
        wr(`CDPA_ADR_AUTO, 32'h00000043);
        repeat (140) @(posedge clock);
        `CHK(cen, 3'b111)
        rchk(`CDPA_ADR_STAT, 32'h00000017);
        do_reset;
        test_done;
    end
endmodule
`default_nettype wire
